// ===== design/b_leg_shift_register.sv
// B operand register with shift/load/hold and registered B-leg output
//
// Functional notes
// RQ1: The register is 16 bits wide and loads in parallel from the A-side mux output.
// RQ2: It changes only on the clock: both mode bits high load, lo-only shifts right, hi-only shifts left, neither holds.
// RQ3: The controller drives mode_sel_hi from control bit 04 and mode_sel_lo from control bit 05.
// RQ4: The register updates on the single clock edge shared with the rest of the datapath.
// RQ5: Serial inputs are used only while shifting and ignored on load and hold.
// RQ6: A left shift puts serial_left_in into bit 0, a right shift puts serial_right_in into bit 15.
// RQ7: The controller picks the leg mode with bit 16 (low enable) and bit 14 (high select).
// RQ8: With low enable set the low register byte reaches the leg, otherwise leg bits 7..1 sit high and bit 0 carries the +1.
// RQ9: The leg is active low, an electrical low meaning logical one.
// RQ10: The high byte mux enable is the inverse of the +1 active signal, so it equals the low byte enable.
// RQ11: An enabled high mux gives bits 15..8 when select is high or bit 7 repeated when low, else all high.
// RQ12: Unmodified mode places the whole register on the leg unchanged.
// RQ13: Sign-extend mode passes the low byte and copies bit 7 into leg bits 15..8.
// RQ14: Constant mode gives logical one on bit 0 and logical zero on bits 15..1.
// RQ15: The controller keeps the inhibit line high when +1 is wanted; +1 needs it high and low enable low.
// RQ16: Sign extension serves byte and branch work, and +1 serves stepping registers by two.
// RQ17: With low enable clear the high select is ignored, so that combination acts as constant mode.
`include "b_leg_regs.svh"

module b_leg_shift_register #(
  parameter int WIDTH = `B_REG_WIDTH
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_a_side_mux_out,
  input  wire logic             i_mode_sel_hi,
  input  wire logic             i_mode_sel_lo,
  input  wire logic             i_serial_left_in,
  input  wire logic             i_serial_right_in,
  input  wire logic             i_low_byte_enable,
  input  wire logic             i_high_byte_select,
  input  wire logic             i_plus_one_inhibit_n,
  output logic      [WIDTH-1:0] o_b_operand_register,
  output logic      [WIDTH-1:0] o_b_leg_bus,
  output logic                  o_plus_one_active,
  output b_leg_pkg::leg_mode_e  o_leg_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding

  function automatic b_leg_pkg::reg_op_e decode_op(input logic hi, input logic lo);
    b_leg_pkg::reg_op_e op;
    op = b_leg_pkg::op_hold;
    case ({hi, lo})
      2'h3:    op = b_leg_pkg::op_load;
      2'h1:    op = b_leg_pkg::op_shift_right;
      2'h2:    op = b_leg_pkg::op_shift_left;
      2'h0:    op = b_leg_pkg::op_hold;
      default: op = b_leg_pkg::op_hold;
    endcase
    return op;
  endfunction : decode_op

  function automatic b_leg_pkg::leg_mode_e decode_leg(input logic low_en, input logic hi_sel);
    b_leg_pkg::leg_mode_e m;
    m = b_leg_pkg::leg_constant;
    case ({low_en, hi_sel})
      2'h3:    m = b_leg_pkg::leg_unmodified;
      2'h2:    m = b_leg_pkg::leg_sign_ext;
      default: m = b_leg_pkg::leg_constant;
    endcase
    return m;
  endfunction : decode_leg

  b_leg_pkg::reg_op_e cur_op;
  logic [WIDTH-1:0]   b_operand_register;
  logic [WIDTH-1:0]   next_b_operand_register;
  logic [WIDTH-1:0]   next_leg_n;
  logic               next_plus_one_active;

  assign cur_op = decode_op(i_mode_sel_hi, i_mode_sel_lo);

  ////////////////////////////////////////////////////////////////////////////
  // Register next value

  always_comb begin
    next_b_operand_register = b_operand_register;
    case (cur_op)
      // RQ1 parallel load
      b_leg_pkg::op_load: begin
        next_b_operand_register = i_a_side_mux_out;
      end
      // RQ6 serial right into MSB
      // RQ5 serial only on shift
      b_leg_pkg::op_shift_right: begin
        next_b_operand_register = {i_serial_right_in, b_operand_register[WIDTH-1:1]};
      end
      // RQ6 serial left into LSB
      b_leg_pkg::op_shift_left: begin
        next_b_operand_register = {b_operand_register[WIDTH-2:0], i_serial_left_in};
      end
      b_leg_pkg::op_hold: begin
        next_b_operand_register = b_operand_register;
      end
      default: begin
        next_b_operand_register = b_operand_register;
      end
    endcase
  end

  // RQ2 clocked mode update
  // RQ4 common datapath edge
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      b_operand_register <= `B_REG_RESET;
    end else begin
      b_operand_register <= next_b_operand_register;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_b_operand_register <= `B_REG_RESET;
    end else begin
      o_b_operand_register <= next_b_operand_register;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // B-leg output, registered one cycle after the controls

  b_leg_output_mux #(
    .WIDTH (WIDTH)
  ) u_out_mux (
    .i_reg_value          (b_operand_register),
    .i_low_byte_enable    (i_low_byte_enable),
    .i_high_byte_select   (i_high_byte_select),
    .i_plus_one_inhibit_n (i_plus_one_inhibit_n),
    .o_leg_n              (next_leg_n),
    .o_plus_one_active    (next_plus_one_active)
  );

  // RQ12 leg output stage
  // RQ16 sign extend and increment modes
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_b_leg_bus       <= `B_LEG_IDLE;
      o_plus_one_active <= `B_PLUS_ONE_RESET;
    end else begin
      o_b_leg_bus       <= next_leg_n;
      o_plus_one_active <= next_plus_one_active;
    end
  end

  // RQ17 mode indicator
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_leg_mode <= b_leg_pkg::leg_constant;
    end else begin
      o_leg_mode <= decode_leg(i_low_byte_enable, i_high_byte_select);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  load_data_a: assert property ( // RQ1
    i_mode_sel_hi && i_mode_sel_lo |=> b_operand_register == $past(i_a_side_mux_out))
    else $error("Parallel load did not take the A-side value");

  hold_data_a: assert property ( // RQ2
    !i_mode_sel_hi && !i_mode_sel_lo |=> $stable(b_operand_register))
    else $error("Register changed during hold");

  shift_right_a: assert property ( // RQ6
    !i_mode_sel_hi && i_mode_sel_lo |=>
      b_operand_register == {$past(i_serial_right_in), $past(b_operand_register[15:1])})
    else $error("Right shift result wrong");

  shift_left_a: assert property ( // RQ5
    i_mode_sel_hi && !i_mode_sel_lo |=>
      b_operand_register == {$past(b_operand_register[14:0]), $past(i_serial_left_in)})
    else $error("Left shift result wrong");

  out_copy_a: assert property ( // RQ4
    o_b_operand_register == b_operand_register)
    else $error("Register output differs from register");

  unmodified_leg_a: assert property ( // RQ12
    i_low_byte_enable && i_high_byte_select |=> o_b_leg_bus == ~$past(b_operand_register))
    else $error("Unmodified leg wrong");

  sign_ext_leg_a: assert property ( // RQ13
    i_low_byte_enable && !i_high_byte_select |=>
      o_b_leg_bus == ~{{8{$past(b_operand_register[7])}}, $past(b_operand_register[7:0])})
    else $error("Sign extended leg wrong");

  plus_one_leg_a: assert property ( // RQ14
    !i_low_byte_enable && i_plus_one_inhibit_n |=> o_b_leg_bus == 16'hFFFE)
    else $error("Constant one not on leg");

  inhibit_leg_a: assert property ( // RQ15
    !i_low_byte_enable && !i_plus_one_inhibit_n |=> o_b_leg_bus == 16'hFFFF)
    else $error("Inhibited constant leg not idle");

  plus_one_flag_a: assert property ( // RQ10
    o_plus_one_active == (o_leg_mode == b_leg_pkg::leg_constant))
    else $error("Plus one flag disagrees with leg mode");

  ////////////////////////////////////////////////////////////////////////////
  // Per-byte leg checks, flag and mode status

  low_byte_gate_a: assert property ( // RQ8
    !i_low_byte_enable |=>
      o_b_leg_bus[7:1] == 7'h7F)
    else $error("Disabled low byte not idle");

  low_byte_pass_a: assert property ( // RQ8
    i_low_byte_enable |=>
      o_b_leg_bus[7:0] == ~$past(b_operand_register[7:0]))
    else $error("Enabled low byte wrong");

  high_byte_off_a: assert property ( // RQ11
    !i_low_byte_enable |=>
      o_b_leg_bus[15:8] == 8'hFF)
    else $error("Disabled high byte not idle");

  high_byte_sel_a: assert property ( // RQ11
    i_low_byte_enable && i_high_byte_select |=>
      o_b_leg_bus[15:8] == ~$past(b_operand_register[15:8]))
    else $error("Selected high byte wrong");

  high_byte_sign_a: assert property ( // RQ11
    i_low_byte_enable && !i_high_byte_select |=>
      o_b_leg_bus[15:8] == {8{~$past(b_operand_register[7])}})
    else $error("Sign copy into high byte wrong");

  select_ignored_a: assert property ( // RQ17
    !i_low_byte_enable && i_high_byte_select && i_plus_one_inhibit_n |=>
      o_b_leg_bus == 16'hFFFE)
    else $error("High select not ignored in constant mode");

  leg_zero_bits_a: assert property ( // RQ14
    !i_low_byte_enable |=>
      o_b_leg_bus[15:1] == 15'h7FFF)
    else $error("Constant mode upper bits not logical zero");

  active_leg_a: assert property ( // RQ9
    i_low_byte_enable && i_high_byte_select |=>
      ~o_b_leg_bus == $past(b_operand_register))
    else $error("Leg not active low");

  mode_unmod_a: assert property ( // RQ12
    i_low_byte_enable && i_high_byte_select |=>
      o_leg_mode == b_leg_pkg::leg_unmodified)
    else $error("Mode not unmodified");

  mode_sign_a: assert property ( // RQ13
    i_low_byte_enable && !i_high_byte_select |=>
      o_leg_mode == b_leg_pkg::leg_sign_ext)
    else $error("Mode not sign extend");

  mode_const_a: assert property ( // RQ17
    !i_low_byte_enable |=>
      o_leg_mode == b_leg_pkg::leg_constant)
    else $error("Mode not constant");

  plus_on_a: assert property ( // RQ10
    !i_low_byte_enable |=>
      o_plus_one_active)
    else $error("Plus one flag missing");

  plus_off_a: assert property ( // RQ10
    i_low_byte_enable |=>
      !o_plus_one_active)
    else $error("Plus one flag stuck");

  mode_onehot_a: assert property ( // RQ7
    1'b1 |->
      $onehot(o_leg_mode))
    else $error("Leg mode not one-hot");

  ////////////////////////////////////////////////////////////////////////////
  // Register bit-level checks

  right_msb_a: assert property ( // RQ6
    !i_mode_sel_hi && i_mode_sel_lo |=>
      b_operand_register[15] == $past(i_serial_right_in))
    else $error("Right shift MSB not from serial right");

  left_lsb_a: assert property ( // RQ6
    i_mode_sel_hi && !i_mode_sel_lo |=>
      b_operand_register[0] == $past(i_serial_left_in))
    else $error("Left shift LSB not from serial left");

  right_body_a: assert property ( // RQ5
    !i_mode_sel_hi && i_mode_sel_lo |=>
      b_operand_register[14:0] == $past(b_operand_register[15:1]))
    else $error("Right shift body wrong");

  left_body_a: assert property ( // RQ5
    i_mode_sel_hi && !i_mode_sel_lo |=>
      b_operand_register[15:1] == $past(b_operand_register[14:0]))
    else $error("Left shift body wrong");

  hold_out_a: assert property ( // RQ2
    !i_mode_sel_hi && !i_mode_sel_lo |=>
      $stable(o_b_operand_register))
    else $error("Register output changed during hold");

  shift_right_c: cover property (
    (!i_mode_sel_hi && i_mode_sel_lo) [*2]);
  load_cover_c: cover property (
    i_mode_sel_hi && i_mode_sel_lo ##1 !i_mode_sel_hi && i_mode_sel_lo);
  shift_left_c: cover property (
    (i_mode_sel_hi && !i_mode_sel_lo) [*2]);
  sign_ext_c: cover property (
    i_low_byte_enable && !i_high_byte_select && b_operand_register[7]);
  plus_one_c: cover property (
    !i_low_byte_enable && i_high_byte_select && i_plus_one_inhibit_n);

endmodule : b_leg_shift_register

// ===== design/b_leg_regs.svh
// Constants for the B operand register and its B-leg output logic
`ifndef B_LEG_REGS_SVH
`define B_LEG_REGS_SVH

`define B_REG_WIDTH        16
`define B_BYTE_WIDTH       8
`define B_SIGN_BIT         7
`define B_LSB_POS          0
`define B_MSB_POS          15
`define B_REG_RESET        16'h0000
`define B_LEG_IDLE         16'hFFFF
`define B_PLUS_ONE_RESET   1'b1
`define B_OUT_LATENCY      1

`endif

// ===== design/b_leg_pkg.sv
// Types shared by the B operand register and its output logic
package b_leg_pkg;

  // Register operation, one-hot
  typedef enum logic [3:0] {
    op_hold        = 4'h1,
    op_shift_right = 4'h2,
    op_shift_left  = 4'h4,
    op_load        = 4'h8
  } reg_op_e;

  // B-leg output mode, one-hot
  typedef enum logic [2:0] {
    leg_unmodified = 3'h1,
    leg_sign_ext   = 3'h2,
    leg_constant   = 3'h4
  } leg_mode_e;

endpackage : b_leg_pkg

// ===== design/b_leg_output_mux.sv
// Combinational B-leg drive: low byte gates, high byte mux and +1 logic
`include "b_leg_regs.svh"

module b_leg_output_mux #(
  parameter int WIDTH = `B_REG_WIDTH
) (
  input  wire logic [WIDTH-1:0] i_reg_value,
  input  wire logic             i_low_byte_enable,
  input  wire logic             i_high_byte_select,
  input  wire logic             i_plus_one_inhibit_n,
  output logic      [WIDTH-1:0] o_leg_n,
  output logic                  o_plus_one_active
);

  localparam int BW = `B_BYTE_WIDTH;

  logic high_mux_enable;
  logic plus_one_pull;

  // RQ10 high mux enable
  assign o_plus_one_active = ~i_low_byte_enable;
  assign high_mux_enable   = ~o_plus_one_active;
  assign plus_one_pull     = o_plus_one_active & i_plus_one_inhibit_n;

  always_comb begin
    // RQ8 low byte gates
    // RQ9 active-low drive
    for (int i = 0; i < BW; i++) begin
      o_leg_n[i] = i_low_byte_enable ? ~i_reg_value[i] : 1'b1;
    end
    // RQ14 plus one wired onto bit 0
    if (plus_one_pull) begin
      o_leg_n[`B_LSB_POS] = 1'b0;
    end
    // RQ11 high byte mux
    // RQ17 select ignored when disabled
    for (int i = BW; i < WIDTH; i++) begin
      if (!high_mux_enable) begin
        o_leg_n[i] = 1'b1;
      end else if (i_high_byte_select) begin
        o_leg_n[i] = ~i_reg_value[i];
      end else begin
        // RQ13 sign bit copied
        o_leg_n[i] = ~i_reg_value[`B_SIGN_BIT];
      end
    end
  end

endmodule : b_leg_output_mux

// ===== bench/control_store_model.sv
// Control store model driving the B register mode and B-leg control fields
module control_store_model (
  input  wire logic [16:0] i_cw,
  input  wire logic        i_block_plus_one,
  output logic             o_mode_sel_hi,
  output logic             o_mode_sel_lo,
  output logic             o_low_byte_enable,
  output logic             o_high_byte_select,
  output logic             o_plus_one_inhibit_n
);
  timeunit 1ns;
  timeprecision 1ns;

  ////////////////////////////////////////////////////////////////////////////
  // register mode and B-leg control bits
  assign o_mode_sel_hi = i_cw[4];
  assign o_mode_sel_lo = i_cw[5];
  assign o_low_byte_enable  = i_cw[16];
  assign o_high_byte_select = i_cw[14];
  assign o_plus_one_inhibit_n = ~i_block_plus_one;
endmodule : control_store_model

// ===== bench/b_leg_shift_register_bench.sv
// Self-checking bench for the B operand register and its B-leg output
`define CHK(act, exp) begin samples_checked++; if ((act) !== (exp)) begin bad_count++; \
  $display("BAD %0t %h %h", $time, act, exp); end end

module b_leg_shift_register_bench;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [16:0] LD = 17'h00030;
  localparam logic [16:0] SHR = 17'h00020;
  localparam logic [16:0] SHL = 17'h00010;
  localparam logic [16:0] LE = 17'h10000;
  localparam logic [16:0] HS = 17'h04000;

  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic [16:0] cw      = 17'h00000;
  logic        blk     = 1'b0;
  logic [15:0] a_in    = 16'h0000;
  logic        sl_in   = 1'b0;
  logic        sr_in   = 1'b0;
  logic        hi, lo, le, hs, inh_n, p1;
  logic [15:0] reg_out, leg;
  b_leg_pkg::leg_mode_e mode;
  int          bad_count       = 0;
  int          samples_checked = 0;
  int          cycles          = 0;

  ////////////////////////////////////////////////////////////////////////////
  control_store_model u_control_store_model (
    .i_cw(cw), .i_block_plus_one(blk), .o_mode_sel_hi(hi), .o_mode_sel_lo(lo),
    .o_low_byte_enable(le), .o_high_byte_select(hs), .o_plus_one_inhibit_n(inh_n)
  );

  b_leg_shift_register u_b_leg_shift_register (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_a_side_mux_out(a_in),
    .i_mode_sel_hi(hi), .i_mode_sel_lo(lo), .i_serial_left_in(sl_in),
    .i_serial_right_in(sr_in), .i_low_byte_enable(le), .i_high_byte_select(hs),
    .i_plus_one_inhibit_n(inh_n), .o_b_operand_register(reg_out), .o_b_leg_bus(leg),
    .o_plus_one_active(p1), .o_leg_mode(mode)
  );

  always #20 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("bad_count=%0d samples_checked=%0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      give_verdict();
    end
  end

  // Drive one cycle of controls, then sample after the edge
  task automatic drive(input logic [16:0] w, input logic [15:0] a, input logic l,
                       input logic r, input logic b);
    cw    = w;
    a_in  = a;
    sl_in = l;
    sr_in = r;
    blk   = b;
    @(posedge sys_clk);
    #1;
  endtask : drive

  ////////////////////////////////////////////////////////////////////////////
  task automatic reg_ops;
    drive(LD, 16'h1234, 1'b0, 1'b0, 1'b0);
    `CHK(reg_out, 16'h1234)
    drive(SHR, 16'hFFFF, 1'b0, 1'b1, 1'b0);
    `CHK(reg_out, 16'h891A)
    drive(SHL, 16'hFFFF, 1'b1, 1'b0, 1'b0);
    `CHK(reg_out, 16'h1235)
    drive(17'h00000, 16'h0F0F, 1'b1, 1'b1, 1'b0);
    `CHK(reg_out, 16'h1235)
    drive(LD, 16'h8001, 1'b1, 1'b1, 1'b0);
    `CHK(reg_out, 16'h8001)
    drive(SHR, 16'hFFFF, 1'b1, 1'b0, 1'b0);
    `CHK(reg_out, 16'h4000)
    drive(SHL, 16'hFFFF, 1'b0, 1'b1, 1'b0);
    `CHK(reg_out, 16'h8000)
    drive(SHL, 16'hFFFF, 1'b1, 1'b0, 1'b0);
    `CHK(reg_out, 16'h0001)
  endtask : reg_ops

  task automatic leg_modes;
    drive(LD, 16'h5A80, 1'b0, 1'b0, 1'b0);
    drive(LE | HS, 16'h0000, 1'b0, 1'b0, 1'b0);
    `CHK(leg, 16'hA57F)
    `CHK(mode, b_leg_pkg::leg_unmodified)
    drive(LD | LE, 16'h5A7F, 1'b0, 1'b0, 1'b0);
    `CHK(leg, 16'h007F)
    `CHK(mode, b_leg_pkg::leg_sign_ext)
    drive(LE, 16'h0000, 1'b0, 1'b0, 1'b0);
    `CHK(leg, 16'hFF80)
    drive(17'h00000, 16'h0000, 1'b0, 1'b0, 1'b0);
    `CHK(leg, 16'hFFFE)
    `CHK(p1, 1'b1)
    `CHK(mode, b_leg_pkg::leg_constant)
    drive(HS, 16'h0000, 1'b0, 1'b0, 1'b0);
    `CHK(leg, 16'hFFFE)
    drive(17'h00000, 16'h0000, 1'b0, 1'b0, 1'b1);
    `CHK(leg, 16'hFFFF)
    drive(LE | HS, 16'h0000, 1'b0, 1'b0, 1'b1);
    `CHK(leg, 16'hA580)
  endtask : leg_modes

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    reg_ops();
    leg_modes();
    give_verdict();
  end
endmodule : b_leg_shift_register_bench
